// ---- hw/cal_clock_pkg.sv ----
package cal_clock_pkg;
	// register addresses (word index on the plain port)
	localparam logic [2:0] ADDR_CAL_CFG   = 3'h0;
	localparam logic [2:0] ADDR_ALM_CFG   = 3'h1;
	localparam logic [2:0] ADDR_TIME_WIN  = 3'h2;
	localparam logic [2:0] ADDR_ALM_WIN   = 3'h3;
	localparam logic [2:0] ADDR_KEY       = 3'h4;
	localparam logic [2:0] ADDR_PAD_CFG   = 3'h5;
	// calendar config fields, plus the pad config seconds select bit
	localparam int BIT_EN      = 15;
	localparam int BIT_WREN    = 13;
	localparam int BIT_SYNC    = 12;
	localparam int BIT_HALF    = 11;
	localparam int BIT_OE      = 10;
	localparam int PTR_HI      = 9;
	localparam int PTR_LO      = 8;
	localparam int BIT_SECSEL  = 1;
	// unlock sequence
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [1:0] KEY_WINDOW = 2'h2;
	// pointer codes
	localparam logic [1:0] PTR_MINUTES_SECONDS_REG = 2'h0;
	localparam logic [1:0] PTR_WDHR   = 2'h1;
	localparam logic [1:0] PTR_MODAY  = 2'h2;
	localparam logic [1:0] PTR_YEAR   = 2'h3;
	// timebase
	localparam logic [14:0] TICKS_PER_SEC = 15'h7fff;
	localparam logic [14:0] TICKS_HALF    = 15'h3fff;
	localparam logic [7:0]  RIPPLE_WIN    = 8'h20;
	localparam logic [14:0] CAL_STEP      = 15'h0004;
	localparam logic [5:0]  SEC_PER_MIN   = 6'h3b;
	// bcd limits and reset values
	localparam logic [7:0] BCD_59  = 8'h59;
	localparam logic [7:0] BCD_23  = 8'h23;
	localparam logic [7:0] BCD_99  = 8'h99;
	localparam logic [7:0] BCD_12  = 8'h12;
	localparam logic [7:0] BCD_01  = 8'h01;
	localparam logic [7:0] BCD_00  = 8'h00;
	localparam logic [7:0] WD_MAX  = 8'h06;
	localparam logic [7:0] DAY_28  = 8'h28;
	localparam logic [7:0] DAY_29  = 8'h29;
	localparam logic [7:0] DAY_30  = 8'h30;
	localparam logic [7:0] DAY_31  = 8'h31;
	localparam logic [7:0] MON_FEB = 8'h02;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage

// ---- hw/bcd_step.sv ----
`timescale 1ns/1ps
`default_nettype none
// one bcd digit pair increment with wrap
module bcd_step (
	input  wire logic [7:0] val,     // current bcd value
	input  wire logic [7:0] top,     // last value before wrap
	input  wire logic [7:0] bottom,  // value after wrap
	output logic      [7:0] nxt,     // next value
	output logic            wrap     // value wraps
);
	import cal_clock_pkg::*;
	always_comb begin
		wrap = (val == top);
		if (wrap) begin
			nxt = bottom;
		end else if (val[3:0] == BCD_NINE) begin
			nxt = {val[7:4] + 4'h1, 4'h0};
		end else begin
			nxt = {val[7:4], val[3:0] + 4'h1};
		end
	end
endmodule
`default_nettype wire

// ---- hw/tick_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-flop sampler for the crystal clock plus rising edge pulse
module tick_sync (
	input  wire logic mclk,  // system clock
	input  wire logic srst,  // sync reset
	input  wire logic xtal,  // 32.768 khz crystal level
	output logic      rise   // one pulse per crystal cycle
);
	logic s1_q, s2_q, s3_q;
	always_ff @(posedge mclk) begin
		if (srst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= xtal;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign rise = s2_q & ~s3_q;
endmodule
`default_nettype wire

// ---- hw/calendar_clock_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: calendar config bits 9:8 pick the time register pair shown in the window.
// R2: time pointer 0 min/sec, 1 weekday/hours, 2 month/day, 3 year only.
// R3: high-byte time window write steps the pointer down while write-enable is set, holding at zero.
// R4: alarm config bits 9:8 pick the alarm register pair shown.
// R5: alarm pointer 0 min/sec, 1 weekday/hours, 2 month/day, 3 nothing.
// R6: high-byte alarm window write steps the alarm pointer down, holding zero.
// R7: any read of either window steps its pointer down.
// R8: time counter writes are dropped unless write-enable bit 13 is set.
// R9: write-enable sets only right after the 55h then AAh key writes.
// R10: software should keep write-enable clear except while setting time.
// R11: hours count 00 to 23, no twelve-hour mode.
// R12: calendar covers years 2000 to 2099 with automatic leap years.
// R13: one-second resolution with the half-second phase visible.
// R14: all time, calendar and alarm values are bcd.
// R15: counting runs from the external 32.768 khz crystal.
// R16: signed calibration adds or removes crystal ticks once a minute.
// R17: output pin gives alarm pulse or seconds clock by configuration.
// R18: module enable only changes while write-enable is set.
// R19: read-only sync flag is set while a rollover may ripple.
// R20: half-second flag is high in the second half; low-byte min/sec write clears.
// R21: seconds advance every 32768 crystal ticks; half flag at midpoint.
// R22: time and alarm pointers are independent.
module calendar_clock_unit
	import cal_clock_pkg::*;
(
	input  wire logic        mclk,       // 10 mhz system clock
	input  wire logic        srst,       // sync reset, high
	input  wire logic        xtal,       // crystal timebase
	input  wire logic [2:0]  addr,       // register index
	input  wire logic [15:0] wdata,      // write data
	input  wire logic [1:0]  wbe,        // byte enables for writes
	input  wire logic        wr,         // write strobe
	input  wire logic        rd,         // read strobe
	output logic      [15:0] rdata,      // read data, cycle after rd
	output logic             clk_out,    // output pin level
	output logic             alarm_hit   // alarm match pulse
);
	import cal_clock_pkg::*;

	typedef struct packed {
		logic [15:0] rdata;
		logic        pin;
		logic        hit;
		logic        en;
		logic        wren;
		logic        oe;
		logic        half;
		logic [1:0]  tptr;
		logic [7:0]  cal;
		logic        alen;
		logic [1:0]  aptr;
		logic        secsel;
		logic [1:0]  key;      // unlock stage
		logic [1:0]  keyage;   // cycles left in the unlock window
		logic [15:0] div;      // spare top bit so positive trim fits
		logic [5:0]  calsec;
		logic [7:0]  ripple;
		logic [7:0]  sec, min, hr, wd, day, mon, yr;
		logic [7:0]  asec, amin, ahr, awd, aday, amon;
	} state_t;

	state_t s_q, s_d;
	logic tick;
	logic [7:0] sec_n, min_n, hr_n, wd_n, day_n, mon_n, yr_n;
	logic sec_w, min_w, hr_w, wd_w, day_w, mon_w, yr_w;
	logic [7:0] day_top;
	logic leap;
	logic [15:0] div_top;

	tick_sync u_sync (                                 // R15
		.mclk (mclk),
		.srst (srst),
		.xtal (xtal),
		.rise (tick)
	);

	// bcd counter chain, 24 hour, 2000-2099
	bcd_step u_sec (.val(s_q.sec), .top(BCD_59), .bottom(BCD_00),
		.nxt(sec_n), .wrap(sec_w));
	bcd_step u_min (.val(s_q.min), .top(BCD_59), .bottom(BCD_00),
		.nxt(min_n), .wrap(min_w));
	bcd_step u_hr  (.val(s_q.hr), .top(BCD_23), .bottom(BCD_00), // R11
		.nxt(hr_n), .wrap(hr_w));
	bcd_step u_wd  (.val(s_q.wd), .top(WD_MAX), .bottom(BCD_00),
		.nxt(wd_n), .wrap(wd_w));
	bcd_step u_day (.val(s_q.day), .top(day_top), .bottom(BCD_01),
		.nxt(day_n), .wrap(day_w));
	bcd_step u_mon (.val(s_q.mon), .top(BCD_12), .bottom(BCD_01),
		.nxt(mon_n), .wrap(mon_w));
	bcd_step u_yr  (.val(s_q.yr), .top(BCD_99), .bottom(BCD_00), // R12
		.nxt(yr_n), .wrap(yr_w));

	// bcd year divisible by four: tens even with ones 0/4/8, odd with 2/6
	always_comb begin
		leap = s_q.yr[4] ? (s_q.yr[1:0] == 2'h2)
			: (s_q.yr[1:0] == 2'h0);                     // R12
		case (s_q.mon)
			MON_FEB: day_top = leap ? DAY_29 : DAY_28;
			8'h04, 8'h06, 8'h09, 8'h11: day_top = DAY_30;
			default: day_top = DAY_31;
		endcase
	end

	// calibration stretches or trims the last second of each minute
	always_comb begin
		div_top = 16'(TICKS_PER_SEC);                   // R21
		if (s_q.calsec == SEC_PER_MIN) begin
			div_top = s_q.cal[7]
				? 16'(TICKS_PER_SEC) - 16'({~s_q.cal + 8'h01, 2'h0})
				: 16'(TICKS_PER_SEC) + 16'({s_q.cal, 2'h0}); // R16
		end
	end

	logic tw_hi, tw_lo, aw_hi, aw_lo, sec_evt, time_ok;
	always_comb begin
		tw_hi   = wr && addr == ADDR_TIME_WIN && wbe[1];
		tw_lo   = wr && addr == ADDR_TIME_WIN && wbe[0];
		aw_hi   = wr && addr == ADDR_ALM_WIN && wbe[1];
		aw_lo   = wr && addr == ADDR_ALM_WIN && wbe[0];
		time_ok = s_q.wren;                             // R8
		sec_evt = s_q.en && tick && s_q.div >= div_top;
	end

	always_comb begin
		s_d = s_q;
		s_d.hit = 1'b0;
		// timebase
		if (s_q.en && tick) begin
			if (sec_evt) begin
				s_d.div = '0;
			end else begin
				s_d.div = s_q.div + 16'h0001;
			end
			if (s_q.div == 16'(TICKS_HALF)) begin
				s_d.half = 1'b1;                         // R20 R21
			end
		end
		if (s_q.ripple != BCD_00) begin
			s_d.ripple = s_q.ripple - 8'h01;
		end
		if (sec_evt) begin
			s_d.half   = 1'b0;                           // R13
			s_d.ripple = RIPPLE_WIN;                     // R19
			s_d.calsec = (s_q.calsec == SEC_PER_MIN) ? 6'h00
				: s_q.calsec + 6'h01;
			s_d.sec = sec_n;
			if (sec_w) begin
				s_d.min = min_n;
				if (min_w) begin
					s_d.hr = hr_n;
					if (hr_w) begin
						s_d.wd  = wd_n;
						s_d.day = day_n;
						if (day_w) begin
							s_d.mon = mon_n;
							if (mon_w) begin
								s_d.yr = yr_n;
							end
						end
					end
				end
			end
			// advanced time, so a minute carry still matches
			if (s_q.alen && s_d.sec == s_q.asec && s_d.min == s_q.amin) begin
				s_d.hit = 1'b1;
			end
		end
		// output pin: seconds clock or alarm pulse
		s_d.pin = s_q.oe && (s_q.secsel ? ~s_q.half : s_q.hit); // R17

		// unlock key sequencer
		if (s_q.keyage != 2'h0) begin
			s_d.keyage = s_q.keyage - 2'h1;
		end
		if (wr && addr == ADDR_KEY) begin
			s_d.keyage = 2'h0;
			if (wdata[7:0] == KEY_FIRST) begin
				s_d.key = 2'h1;
			end else if (wdata[7:0] == KEY_SECOND && s_q.key == 2'h1) begin
				s_d.key    = 2'h2;                       // R9
				s_d.keyage = KEY_WINDOW;
			end else begin
				s_d.key = 2'h0;
			end
		end else if (wr || (s_q.key == 2'h2 && s_q.keyage == 2'h0)) begin
			s_d.key = (wr && addr == ADDR_CAL_CFG) ? s_q.key
				: (s_q.key == 2'h2 && s_q.keyage != 2'h0) ? s_q.key : 2'h0;
		end

		// calendar config writes
		if (wr && addr == ADDR_CAL_CFG) begin
			s_d.key = 2'h0;
			if (wbe[1]) begin
				if (!wdata[BIT_WREN]) begin
					s_d.wren = 1'b0;
				end else if (s_q.key == 2'h2 && s_q.keyage != 2'h0) begin
					s_d.wren = 1'b1;                     // R9
				end
				if (s_q.wren) begin
					s_d.en = wdata[BIT_EN];              // R18
				end
				s_d.oe   = wdata[BIT_OE];
				s_d.tptr = wdata[PTR_HI:PTR_LO];         // R1
			end
			if (wbe[0]) begin
				s_d.cal = wdata[7:0];                    // R16
			end
		end
		if (wr && addr == ADDR_ALM_CFG && wbe[1]) begin
			s_d.alen = wdata[15];
			s_d.aptr = wdata[PTR_HI:PTR_LO];             // R4
		end
		if (wr && addr == ADDR_PAD_CFG && wbe[0]) begin
			s_d.secsel = wdata[BIT_SECSEL];
		end

		// time window writes, locked by write-enable
		if (time_ok && (tw_hi || tw_lo)) begin            // R8
			case (s_q.tptr)                               // R2
				PTR_MINUTES_SECONDS_REG: begin
					if (tw_hi) s_d.min = wdata[15:8];
					if (tw_lo) begin
						s_d.sec  = wdata[7:0];
						s_d.half = 1'b0;                 // R20
						s_d.div  = '0;
					end
				end
				PTR_WDHR: begin
					if (tw_hi) s_d.wd = wdata[15:8];
					if (tw_lo) s_d.hr = wdata[7:0];
				end
				PTR_MODAY: begin
					if (tw_hi) s_d.mon = wdata[15:8];
					if (tw_lo) s_d.day = wdata[7:0];
				end
				default: begin
					if (tw_lo) s_d.yr = wdata[7:0];
				end
			endcase
		end
		if (aw_hi || aw_lo) begin                         // R5
			case (s_q.aptr)
				PTR_MINUTES_SECONDS_REG: begin
					if (aw_hi) s_d.amin = wdata[15:8];
					if (aw_lo) s_d.asec = wdata[7:0];
				end
				PTR_WDHR: begin
					if (aw_hi) s_d.awd = wdata[15:8];
					if (aw_lo) s_d.ahr = wdata[7:0];
				end
				PTR_MODAY: begin
					if (aw_hi) s_d.amon = wdata[15:8];
					if (aw_lo) s_d.aday = wdata[7:0];
				end
				default: ;
			endcase
		end
		// pointer stepping, each window touches only its own pointer
		if (((time_ok && tw_hi) || (rd && addr == ADDR_TIME_WIN))
			&& s_q.tptr != PTR_MINUTES_SECONDS_REG) begin
			s_d.tptr = s_q.tptr - 2'h1;                   // R3 R7 R22
		end
		if ((aw_hi || (rd && addr == ADDR_ALM_WIN))
			&& s_q.aptr != PTR_MINUTES_SECONDS_REG) begin
			s_d.aptr = s_q.aptr - 2'h1;                   // R6 R7 R22
		end

		// read data, stands one cycle
		s_d.rdata = WORD_ZERO;
		if (rd) begin
			case (addr)
				ADDR_CAL_CFG: s_d.rdata = {s_q.en, 1'b0, s_q.wren,
					s_q.ripple != BCD_00, s_q.half, s_q.oe,
					s_q.tptr, s_q.cal};                      // R19 R20
				ADDR_ALM_CFG: s_d.rdata = {s_q.alen, 5'h00, s_q.aptr,
					8'h00};
				ADDR_TIME_WIN: begin
					case (s_q.tptr)                         // R2 R14
						PTR_MINUTES_SECONDS_REG: s_d.rdata = {s_q.min, s_q.sec};
						PTR_WDHR:   s_d.rdata = {s_q.wd, s_q.hr};
						PTR_MODAY:  s_d.rdata = {s_q.mon, s_q.day};
						default:    s_d.rdata = {BCD_00, s_q.yr};
					endcase
				end
				ADDR_ALM_WIN: begin
					case (s_q.aptr)                         // R5
						PTR_MINUTES_SECONDS_REG: s_d.rdata = {s_q.amin, s_q.asec};
						PTR_WDHR:   s_d.rdata = {s_q.awd, s_q.ahr};
						PTR_MODAY:  s_d.rdata = {s_q.amon, s_q.aday};
						default:    s_d.rdata = WORD_ZERO;
					endcase
				end
				ADDR_PAD_CFG: s_d.rdata = {14'h0000, s_q.secsel, 1'b0};
				default: s_d.rdata = WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s_q     <= '0;
			s_q.day <= BCD_01;
			s_q.mon <= BCD_01;
			s_q.aday <= BCD_01;
			s_q.amon <= BCD_01;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata     = s_q.rdata;
	assign clk_out   = s_q.pin;
	assign alarm_hit = s_q.hit;

	property p_tptr_step;
		@(posedge mclk) disable iff (srst)
		(rd && addr == ADDR_TIME_WIN && s_q.tptr != PTR_MINUTES_SECONDS_REG)
			|=> s_q.tptr == $past(s_q.tptr) - 2'h1;
	endproperty
	a_tptr_step: assert property (p_tptr_step) else $error("tptr step"); // R7
	property p_lock;
		@(posedge mclk) disable iff (srst)
		(tw_lo && !s_q.wren && s_q.tptr == PTR_WDHR) |=> $stable(s_q.hr);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write taken"); // R8
	property p_hr;
		@(posedge mclk) disable iff (srst) s_q.hr <= BCD_23;
	endproperty
	a_hr: assert property (p_hr) else $error("hour range"); // R11
	property p_en;
		@(posedge mclk) disable iff (srst)
		!s_q.wren |=> $stable(s_q.en);
	endproperty
	a_en: assert property (p_en) else $error("enable changed locked"); // R18

	sequence s_key_pair;
		wr && addr == ADDR_KEY && wdata[7:0] == KEY_FIRST
		##1 wr && addr == ADDR_KEY && wdata[7:0] == KEY_SECOND;
	endsequence
	sequence s_wren_req;
		wr && addr == ADDR_CAL_CFG && wbe[1] && wdata[BIT_WREN];
	endsequence
	property p_unlock;
		@(posedge mclk) disable iff (srst)
		s_key_pair ##1 s_wren_req |=> s_q.wren;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock refused"); // R9
	property p_aptr_step;
		@(posedge mclk) disable iff (srst)
		((aw_hi || (rd && addr == ADDR_ALM_WIN)) && s_q.aptr != PTR_MINUTES_SECONDS_REG)
			|=> s_q.aptr == $past(s_q.aptr) - 2'h1;
	endproperty
	a_aptr_step: assert property (p_aptr_step) else $error("aptr step"); // R6
	property p_half_clr;
		@(posedge mclk) disable iff (srst)
		(tw_lo && s_q.wren && s_q.tptr == PTR_MINUTES_SECONDS_REG) |=> !s_q.half;
	endproperty
	a_half_clr: assert property (p_half_clr) else $error("half kept"); // R20
endmodule
`default_nettype wire

// ---- sim/host_cpu.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_cpu (
	input  wire logic        mclk,   // system clock
	input  wire logic [15:0] rdata,  // read data from the block
	input  wire logic        run,    // crystal running
	output logic      [2:0]  addr,   // register index
	output logic      [15:0] wdata,  // write data
	output logic      [1:0]  wbe,    // byte enables
	output logic             wr,     // write strobe
	output logic             rd,     // read strobe
	output logic             xtal,   // crystal level
	output int               ticks   // crystal rising edges made
);
	import cal_clock_pkg::*;
	initial begin
		addr = 3'h0;
		wdata = 16'h0000;
		wbe = 2'h0;
		wr = 1'b0;
		rd = 1'b0;
		xtal = 1'b0;
		ticks = 0;
	end
	// crystal sped up to 2 clocks a period so a full second fits the run
	always @(posedge mclk) begin
		if (run) begin
			xtal <= ~xtal;
			if (!xtal)
				ticks <= ticks + 1;
		end
	end
	// strobe left high so writes run back to back; next access lowers it
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d,
			input logic [1:0] be);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wbe <= be;
		wr <= 1'b1;
		rd <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask
	task automatic idle();
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// key pair and config write with no gap between them
	task automatic unlock(input logic [15:0] cfg);
		wr_reg(ADDR_KEY, {8'h00, KEY_FIRST}, 2'h3);
		wr_reg(ADDR_KEY, {8'h00, KEY_SECOND}, 2'h3);
		wr_reg(ADDR_CAL_CFG, cfg, 2'h3);
		idle();
	endtask
endmodule
`default_nettype wire

// ---- sim/calendar_clock_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module calendar_clock_unit_bench;
	import cal_clock_pkg::*;
	logic        mclk;
	logic        srst;
	logic        run;
	logic        xtal;
	logic [2:0]  addr;
	logic [15:0] wdata;
	logic [1:0]  wbe;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        clk_out;
	logic        alarm_hit;
	int          ticks;
	int          err_count = 0;
	int          checked = 0;
	int          cycles = 0;

	calendar_clock_unit i_calendar_clock_unit (
		.mclk(mclk), .srst(srst), .xtal(xtal), .addr(addr),
		.wdata(wdata), .wbe(wbe), .wr(wr), .rd(rd), .rdata(rdata),
		.clk_out(clk_out), .alarm_hit(alarm_hit)
	);
	host_cpu i_host_cpu (
		.mclk(mclk), .rdata(rdata), .run(run), .addr(addr),
		.wdata(wdata), .wbe(wbe), .wr(wr), .rd(rd), .xtal(xtal),
		.ticks(ticks)
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic print_verdict();
		if (err_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// half second, clear, then a full second: about 98.5k cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 99500) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic check(input string name, input logic [15:0] seen,
			input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rc(input logic [2:0] a, input logic [15:0] exp,
			input string name);
		logic [15:0] d;
		i_host_cpu.rd_reg(a, d);
		check(name, d, exp);
	endtask

	task automatic t_lock();
		rc(ADDR_CAL_CFG, 16'h0000, "cfg_reset");
		rc(3'h7, 16'h0000, "unmapped");
		i_host_cpu.wr_reg(ADDR_KEY, {8'h00, KEY_SECOND}, 2'h3);
		i_host_cpu.wr_reg(ADDR_KEY, {8'h00, KEY_FIRST}, 2'h3);
		i_host_cpu.wr_reg(ADDR_CAL_CFG, 16'h2000, 2'h3);
		rc(ADDR_CAL_CFG, 16'h0000, "wren_bad_order");
		i_host_cpu.wr_reg(ADDR_CAL_CFG, 16'h8300, 2'h3);
		rc(ADDR_CAL_CFG, 16'h0300, "en_locked");
		i_host_cpu.wr_reg(ADDR_TIME_WIN, 16'h0045, 2'h3);
		rc(ADDR_CAL_CFG, 16'h0300, "ptr_locked_write");
		rc(ADDR_TIME_WIN, 16'h0000, "year_kept");
		rc(ADDR_CAL_CFG, 16'h0200, "ptr_after_read");
		rc(ADDR_TIME_WIN, 16'h0101, "month_day_reset");
		rc(ADDR_CAL_CFG, 16'h0100, "ptr_after_read2");
	endtask

	task automatic t_time();
		i_host_cpu.unlock(16'h2300);
		rc(ADDR_CAL_CFG, 16'h2300, "wren_set");
		i_host_cpu.wr_reg(ADDR_TIME_WIN, 16'h0045, 2'h3);
		i_host_cpu.wr_reg(ADDR_TIME_WIN, 16'h1231, 2'h3);
		i_host_cpu.wr_reg(ADDR_TIME_WIN, 16'h0623, 2'h3);
		i_host_cpu.wr_reg(ADDR_TIME_WIN, 16'h5958, 2'h3);
		rc(ADDR_CAL_CFG, 16'h2000, "ptr_held_zero");
		i_host_cpu.unlock(16'h2300);
		rc(ADDR_TIME_WIN, 16'h0045, "win_year");
		rc(ADDR_TIME_WIN, 16'h1231, "win_month_day");
		rc(ADDR_TIME_WIN, 16'h0623, "win_wday_hour");
		rc(ADDR_TIME_WIN, 16'h5958, "win_min_sec");
		rc(ADDR_TIME_WIN, 16'h5958, "win_hold_zero");
		// lock again once the time is set
		i_host_cpu.wr_reg(ADDR_CAL_CFG, 16'h0000, 2'h3);
		rc(ADDR_CAL_CFG, 16'h0000, "wren_cleared");
	endtask

	task automatic t_alarm();
		rc(ADDR_ALM_CFG, 16'h0000, "alm_cfg_reset");
		i_host_cpu.wr_reg(ADDR_ALM_CFG, 16'h0200, 2'h3);
		i_host_cpu.wr_reg(ADDR_ALM_WIN, 16'h0115, 2'h3);
		i_host_cpu.wr_reg(ADDR_ALM_WIN, 16'h0312, 2'h3);
		i_host_cpu.wr_reg(ADDR_ALM_WIN, 16'h3020, 2'h3);
		rc(ADDR_ALM_CFG, 16'h0000, "alm_ptr_zero");
		rc(ADDR_CAL_CFG, 16'h0000, "time_ptr_untouched");
		i_host_cpu.wr_reg(ADDR_ALM_CFG, 16'h0300, 2'h3);
		rc(ADDR_ALM_WIN, 16'h0000, "alm_ptr3_empty");
		rc(ADDR_ALM_WIN, 16'h0115, "alm_month_day");
		rc(ADDR_ALM_WIN, 16'h0312, "alm_wday_hour");
		rc(ADDR_ALM_WIN, 16'h3020, "alm_min_sec");
		rc(ADDR_ALM_WIN, 16'h3020, "alm_hold_zero");
		rc(ADDR_CAL_CFG, 16'h0000, "time_ptr_still");
	endtask

	task automatic t_half();
		logic [15:0] d;
		int n;
		i_host_cpu.unlock(16'h2000);
		i_host_cpu.wr_reg(ADDR_PAD_CFG, 16'h0002, 2'h3);
		// alarm at 00:00 so the full rollover raises it
		i_host_cpu.wr_reg(ADDR_ALM_CFG, 16'h8000, 2'h3);
		i_host_cpu.wr_reg(ADDR_ALM_WIN, 16'h0000, 2'h3);
		i_host_cpu.wr_reg(ADDR_CAL_CFG, 16'ha400, 2'h3);
		rc(ADDR_CAL_CFG, 16'ha400, "cfg_enabled");
		run <= 1'b1;
		check("clk_first_half", {15'h0, clk_out}, 16'h0001);
		n = 0;
		d = 16'h0000;
		while (d[BIT_HALF] !== 1'b1 && n < 30000) begin
			i_host_cpu.rd_reg(ADDR_CAL_CFG, d);
			n++;
		end
		check("half_flag", d, 16'hac00);
		check("half_ticks", {15'h0, (ticks >= int'(TICKS_HALF) - 4 &&
			ticks <= int'(TICKS_HALF) + 8)}, 16'h0001);
		repeat (2) @(negedge mclk);
		check("clk_second_half", {15'h0, clk_out}, 16'h0000);
		// seconds to 59 so the next second carries through every field
		i_host_cpu.wr_reg(ADDR_TIME_WIN, 16'h0059, 2'h1);
		rc(ADDR_CAL_CFG, 16'ha400, "half_cleared");
		n = 0;
		while (alarm_hit !== 1'b1 && n < 70000) begin
			@(negedge mclk);
			n++;
		end
		check("alarm_pulse", {15'h0, alarm_hit}, 16'h0001);
		rc(ADDR_CAL_CFG, 16'hb400, "sync_after_roll");
		check("clk_after_roll", {15'h0, clk_out}, 16'h0001);
		i_host_cpu.wr_reg(ADDR_CAL_CFG, 16'ha700, 2'h3);
		rc(ADDR_TIME_WIN, 16'h0046, "roll_year");
		rc(ADDR_TIME_WIN, 16'h0101, "roll_month_day");
		rc(ADDR_TIME_WIN, 16'h0000, "roll_wday_hour");
		rc(ADDR_TIME_WIN, 16'h0000, "roll_min_sec");
		run <= 1'b0;
	endtask

	initial begin
		srst = 1'b1;
		run = 1'b0;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		t_lock();
		t_time();
		t_alarm();
		t_half();
		print_verdict();
	end
endmodule
`default_nettype wire
